// ===== wdt_pkg.sv
// Constants, register map and field layout shared by the watchdog design
package wdt_pkg;

  // Bus and counter widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 9;
  localparam int unsigned STAT_W = 2;

  typedef logic [CNT_W-1:0]  wdt_count_t;
  typedef logic [DATA_W-1:0] wdt_word_t;
  typedef logic [STAT_W-1:0] wdt_stat_t;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 32'h5000_3100;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 32'h5000_3102;
  localparam logic [ADDR_W-1:0] ADDR_STAT  = 32'h5000_3104;
  localparam logic [ADDR_W-1:0] ADDR_MASK  = 32'h5000_3106;

  // Count register fields
  localparam int unsigned KEY_HI   = 15;
  localparam int unsigned KEY_LO   = 9;
  localparam int unsigned SIGN_BIT = 8;
  localparam int unsigned VAL_HI   = 7;
  localparam logic [KEY_HI-KEY_LO:0] KEY_OPEN = 7'h00;

  // Control register fields
  localparam int unsigned MODE_BIT = 0;
  localparam int unsigned RSVD_BIT = 1;

  // Event status bits
  localparam int unsigned STAT_NMI = 0;
  localparam int unsigned STAT_RST = 1;

  // Count values
  localparam wdt_count_t CNT_RESET     = 9'h0FF;
  localparam wdt_count_t CNT_RELOAD    = 9'h0FF;
  localparam wdt_count_t CNT_ZERO      = 9'h000;
  localparam wdt_count_t CNT_ONE       = 9'h001;
  localparam wdt_count_t CNT_RST_POINT = 9'h1F0;
  localparam wdt_stat_t  STAT_CLEAR    = 2'h0;
  localparam wdt_word_t  WORD_ZERO     = 16'h0000;

  // Tick timing
  localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
  localparam int unsigned TICK_PERIOD_US = 10240;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned PRESC_W        = 22;

endpackage

// ===== wdt_tick.sv
// Prescaler that turns the system clock into a one-cycle decrement strobe
module wdt_tick
  import wdt_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam logic [PRESC_W-1:0] LAST = PRESC_W'(PERIOD - 1);
  localparam logic [PRESC_W-1:0] ONE  = PRESC_W'(1);

  logic [PRESC_W-1:0] div_r;
  logic [PRESC_W-1:0] div_nxt;
  logic               tick_r;
  logic               tick_nxt;

  // Count up through the period, strobe on wrap
  always_comb begin
    tick_nxt = (div_r == LAST);
    div_nxt  = tick_nxt ? '0 : div_r + ONE;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule

// ===== wdt_top.sv
// Watchdog timer with NMI and system reset, register port and event interrupt
// Notes on behaviour
// (RL1) Write with zero key loads low byte
// (RL2) Write with nonzero key is ignored
// (RL3) Decrement by one every tick
// (RL4) Nine-bit signed count, read returns live value
// (RL5) Mode clear: NMI when count reaches zero
// (RL6) Mode clear: reset at 1F0, reload FF
// (RL7) Mode set: reset at zero or below, reload
// (RL8) Mode clear: freeze set stops, clear resumes
// (RL9) Mode set: freeze requests have no effect; a freeze set is still latched and stops the count once the mode clears
// (RL10) Mode bit set-only, cleared by resets
// (RL11) Debug halt always stops the count
// (RL12) Reset: count FF, sign and mode zero
// (RL13) NMI is one event on reaching zero
// (RL14) Tick comes from a prescaled strobe
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic              freeze_set_in,
  input  wire logic              freeze_clr_in,
  input  wire logic              dbg_halt_in,
  input  wire logic              sw_rst_in,
  output logic                   nmi_out,
  output logic                   sys_rst_out,
  output logic                   irq_out
);

  logic       tick_w;
  wdt_count_t cnt_r;
  wdt_count_t cnt_nxt;
  logic       mode_r;
  logic       mode_nxt;
  logic       rsvd_r;
  logic       rsvd_nxt;
  logic       frozen_r;
  logic       frozen_nxt;
  logic       nmi_r;
  logic       nmi_nxt;
  logic       sys_rst_r;
  logic       sys_rst_nxt;
  wdt_stat_t  stat_r;
  wdt_stat_t  stat_nxt;
  wdt_stat_t  mask_r;
  wdt_stat_t  mask_nxt;
  logic       irq_r;
  logic       irq_nxt;
  wdt_word_t  rd_r;
  wdt_word_t  rd_nxt;

  logic wr_count_w;
  logic wr_ctrl_w;
  logic wr_stat_w;
  logic wr_mask_w;
  logic key_ok_w;
  logic run_w;
  logic dec_w;
  logic fire_w;
  logic nmi_hit_w;

  // Decrement strobe generator
  wdt_tick #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick_w)                                   // RL14
  );

  // Address decode and write key check
  assign wr_count_w = wr_en_in && (addr_in == ADDR_COUNT);
  assign wr_ctrl_w  = wr_en_in && (addr_in == ADDR_CTRL);
  assign wr_stat_w  = wr_en_in && (addr_in == ADDR_STAT);
  assign wr_mask_w  = wr_en_in && (addr_in == ADDR_MASK);
  assign key_ok_w   = (wr_data_in[KEY_HI:KEY_LO] == KEY_OPEN);   // RL1 RL2

  // Run gating: debug halt always, freeze only in NMI mode
  assign run_w = !dbg_halt_in && !(frozen_r && !mode_r);    // RL8 RL9 RL11
  assign dec_w = tick_w && run_w;                            // RL3

  // Reset condition per mode
  always_comb begin
    if (mode_r) begin
      fire_w = cnt_r[SIGN_BIT] || (cnt_r == CNT_ZERO);       // RL7
    end else begin
      fire_w = (cnt_r == CNT_RST_POINT);                     // RL6
    end
  end

  // NMI only on the step down to zero, not when a keyed load wins
  assign nmi_hit_w = dec_w && !mode_r && !fire_w && !(wr_count_w && key_ok_w)
                     && (cnt_r == CNT_ONE);                              // RL5 RL13

  // Counter next value; an unkeyed write must not stall tick or reload
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_count_w && key_ok_w) begin
      cnt_nxt = {1'b0, wr_data_in[VAL_HI:0]};                // RL1 RL2
    end else if (fire_w) begin
      cnt_nxt = CNT_RELOAD;                                  // RL6 RL7
    end else if (dec_w) begin
      cnt_nxt = cnt_r - CNT_ONE;                             // RL3 RL4
    end
  end

  // Mode, freeze and pulse outputs
  always_comb begin
    mode_nxt = mode_r;
    if (fire_w || sw_rst_in) begin
      mode_nxt = 1'b0;                                       // RL10
    end else if (wr_ctrl_w && wr_data_in[MODE_BIT]) begin
      mode_nxt = 1'b1;                                       // RL10
    end
    rsvd_nxt = wr_ctrl_w ? wr_data_in[RSVD_BIT] : rsvd_r;
    frozen_nxt = frozen_r;
    if (freeze_set_in) begin
      frozen_nxt = 1'b1;                                     // RL8
    end else if (freeze_clr_in) begin
      frozen_nxt = 1'b0;                                     // RL8
    end
    nmi_nxt     = nmi_hit_w;                                 // RL5
    sys_rst_nxt = fire_w;                                    // RL6 RL7
  end

  // Sticky event status, write one to clear, set wins
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat_w) begin
      stat_nxt = stat_r & ~wr_data_in[STAT_W-1:0];
    end
    if (nmi_hit_w) begin
      stat_nxt[STAT_NMI] = 1'b1;
    end
    if (fire_w) begin
      stat_nxt[STAT_RST] = 1'b1;
    end
    mask_nxt = wr_mask_w ? wr_data_in[STAT_W-1:0] : mask_r;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    rd_nxt = WORD_ZERO;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_COUNT: rd_nxt = {{(DATA_W-CNT_W){1'b0}}, cnt_r};   // RL4
        ADDR_CTRL: begin
          rd_nxt           = WORD_ZERO;
          rd_nxt[MODE_BIT] = mode_r;
          rd_nxt[RSVD_BIT] = rsvd_r;
        end
        ADDR_STAT: rd_nxt = {{(DATA_W-STAT_W){1'b0}}, stat_r};
        ADDR_MASK: rd_nxt = {{(DATA_W-STAT_W){1'b0}}, mask_r};
        default:   rd_nxt = WORD_ZERO;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r     <= CNT_RESET;                                // RL12
      mode_r    <= 1'b0;                                     // RL12
      rsvd_r    <= 1'b0;
      frozen_r  <= 1'b0;
      nmi_r     <= 1'b0;
      sys_rst_r <= 1'b0;
      stat_r    <= STAT_CLEAR;
      mask_r    <= STAT_CLEAR;
      irq_r     <= 1'b0;
      rd_r      <= WORD_ZERO;
    end else begin
      cnt_r     <= cnt_nxt;
      mode_r    <= mode_nxt;
      rsvd_r    <= rsvd_nxt;
      frozen_r  <= frozen_nxt;
      nmi_r     <= nmi_nxt;
      sys_rst_r <= sys_rst_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      irq_r     <= irq_nxt;
      rd_r      <= rd_nxt;
    end
  end

  // Outputs straight from flops
  assign rd_data_out = rd_r;
  assign nmi_out     = nmi_r;
  assign sys_rst_out = sys_rst_r;
  assign irq_out     = irq_r;

  // Checks on counter, mode and event outputs
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence reload_seq;
    sys_rst_out && (cnt_r == CNT_RELOAD);
  endsequence

  sequence quiet_seq;
    !wr_count_w && !fire_w;
  endsequence

  load_open_a: assert property (                                       // RL1
    wr_count_w && key_ok_w |=> cnt_r == {1'b0, $past(wr_data_in[VAL_HI:0])})
    else $error("count not loaded by keyed write");

  load_block_a: assert property (                                      // RL2
    wr_count_w && !key_ok_w && !fire_w
      |=> cnt_r == ($past(dec_w) ? $past(cnt_r) - CNT_ONE : $past(cnt_r)))
    else $error("count changed by unkeyed write");

  tick_dec_a: assert property (                                        // RL3
    quiet_seq and dec_w |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("count did not step down on tick");

  live_read_a: assert property (                                       // RL4
    rd_en_in && (addr_in == ADDR_COUNT) |=> rd_data_out[CNT_W-1:0] == $past(cnt_r))
    else $error("count read not live");

  nmi_zero_a: assert property (                                        // RL5
    !mode_r && dec_w && !wr_count_w && (cnt_r == CNT_ONE)
      |=> nmi_out && (cnt_r == CNT_ZERO) ##1 !nmi_out)
    else $error("nmi missing or held at zero");

  rst_neg16_a: assert property (                                       // RL6
    !mode_r && (cnt_r == CNT_RST_POINT) && !(wr_count_w && key_ok_w) |=> reload_seq)
    else $error("no reset and reload at minus sixteen");

  rst_mode_a: assert property (                                        // RL7
    mode_r && (cnt_r[SIGN_BIT] || cnt_r == CNT_ZERO) && !(wr_count_w && key_ok_w)
      |=> reload_seq ##0 !nmi_out)
    else $error("reset-only mode did not reset at zero");

  freeze_hold_a: assert property (                                     // RL8
    quiet_seq and (frozen_r && !mode_r) |=> $stable(cnt_r))
    else $error("count moved while frozen");

  freeze_ign_a: assert property (                                      // RL9
    quiet_seq and (mode_r && frozen_r && tick_w && !dbg_halt_in)
      |=> cnt_r != $past(cnt_r))
    else $error("freeze acted in reset-only mode");

  mode_stick_a: assert property (                                      // RL10
    mode_r && !fire_w && !sw_rst_in |=> mode_r)
    else $error("mode bit cleared by software");

  debug_hold_a: assert property (                                      // RL11
    quiet_seq and dbg_halt_in |=> $stable(cnt_r))
    else $error("count moved in debug halt");

  reset_val_a: assert property (@(posedge clk_in) disable iff (1'b0)   // RL12
    rst_in |=> (cnt_r == CNT_RESET) && !mode_r && !irq_out)
    else $error("wrong values after reset");

  irq_stat_a: assert property (
    nmi_out |-> stat_r[STAT_NMI] ##1 (irq_out == (mask_r[STAT_NMI] || $past(irq_out))))
    else $error("nmi event not recorded in status");

  // Pulse widths of the event outputs, and no NMI in reset-only mode
  nmi_pulse_a: assert property (                                       // RL13
    nmi_out |=> !nmi_out)
    else $error("nmi held longer than one cycle");

  rst_pulse_a: assert property (                                       // RL6 RL7
    sys_rst_out |=> !sys_rst_out)
    else $error("system reset held longer than one cycle");

  mode_no_nmi_a: assert property (                                     // RL7
    mode_r |=> !nmi_out)
    else $error("nmi raised in reset-only mode");

  // Status, mask and interrupt level
  nmi_stat_a: assert property (                                        // RL5
    nmi_hit_w |=> stat_r[STAT_NMI])
    else $error("nmi event lost by status clear");

  rst_stat_a: assert property (                                        // RL10
    fire_w |=> stat_r[STAT_RST] && !mode_r)
    else $error("fire did not record or clear mode");

  stat_keep_a: assert property (
    stat_r[STAT_NMI] && !wr_stat_w |=> stat_r[STAT_NMI])
    else $error("nmi status dropped without write");

  irq_level_a: assert property (
    irq_out == |(stat_r & mask_r))
    else $error("interrupt level does not follow status and mask");

  // Read data stand only after a strobe
  rd_idle_a: assert property (
    !rd_en_in |=> rd_data_out == WORD_ZERO)
    else $error("read data shown without strobe");

endmodule

// ===== wdt_core_model.sv
// Model of the processor core and reset logic that take the watchdog events
module wdt_core_model (
  input  wire logic clk_in,
  input  wire logic nmi_in,
  input  wire logic sys_rst_in,
  output int        nmi_cnt_out,
  output int        rst_cnt_out,
  output int        nmi_cyc_out,
  output int        rst_cyc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;

  // Count cycles and log each event pulse with its cycle
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (nmi_in === 1'b1) begin
      nmi_cnt_out <= nmi_cnt_out + 1;
      nmi_cyc_out <= cyc;
    end
    if (sys_rst_in === 1'b1) begin
      rst_cnt_out <= rst_cnt_out + 1;
      rst_cyc_out <= cyc;
    end
  end
endmodule

// ===== wdt_top_tb.sv
// Self-checking bench for the watchdog timer
module wdt_top_tb
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TP = 8;
  logic              clk_in, rst_in, wr_en_in, rd_en_in, sw_rst_in;
  logic              freeze_set_in, freeze_clr_in, dbg_halt_in;
  logic              nmi_out, sys_rst_out, irq_out;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in, rd_data_out;
  int                num_errors, check_count, nmi_cnt, rst_cnt, nmi_cyc, rst_cyc, n;

  // Clock at 200 MHz
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  wdt_top #(.TICK_PERIOD(TP)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .freeze_set_in(freeze_set_in), .freeze_clr_in(freeze_clr_in),
    .dbg_halt_in(dbg_halt_in), .sw_rst_in(sw_rst_in), .nmi_out(nmi_out),
    .sys_rst_out(sys_rst_out), .irq_out(irq_out)
  );

  wdt_core_model u_core (
    .clk_in(clk_in), .nmi_in(nmi_out), .sys_rst_in(sys_rst_out),
    .nmi_cnt_out(nmi_cnt), .rst_cnt_out(rst_cnt), .nmi_cyc_out(nmi_cyc),
    .rst_cyc_out(rst_cyc)
  );

  // Compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask

  // One-cycle register read, data checked in the following cycle
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(rd_data_out, e);
  endtask

  // Freeze set or clear pulse
  task automatic frz(input bit set);
    @(posedge clk_in);
    if (set) freeze_set_in <= 1'b1;
    else freeze_clr_in <= 1'b1;
    @(posedge clk_in);
    freeze_set_in <= 1'b0;
    freeze_clr_in <= 1'b0;
  endtask

  // Bounded wait for an event count to reach a target
  task automatic wait_ev(input bit rst_ev, input int target, input int lim);
    n = 0;
    while ((rst_ev ? rst_cnt : nmi_cnt) < target && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("wrong value at %0t: event did not come", $time);
    end
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  initial begin
    #(5ns * 4000);
    num_errors++;
    close_out;
  end

  // Test sequence
  initial begin
    rst_in = 1'b1;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    sw_rst_in = 1'b0;
    freeze_set_in = 1'b0;
    freeze_clr_in = 1'b0;
    dbg_halt_in = 1'b0;
    addr_in = '0;
    wr_data_in = '0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ADDR_COUNT, 16'h00FF);
    rd(ADDR_CTRL, 16'h0000);
    rd(32'h5000_3108, 16'h0000);
    frz(1'b1);
    wr(ADDR_COUNT, 16'h0042);
    rd(ADDR_COUNT, 16'h0042);
    wr(ADDR_COUNT, 16'h0230);
    rd(ADDR_COUNT, 16'h0042);
    repeat (5 * TP) @(posedge clk_in);
    rd(ADDR_COUNT, 16'h0042);
    wr(ADDR_MASK, 16'h0003);
    wr(ADDR_COUNT, 16'h0002);
    frz(1'b0);
    wait_ev(1'b0, 1, 4 * TP);
    repeat (6) @(posedge clk_in);
    rd(ADDR_COUNT, 16'h01FF);
    chk({15'h0, irq_out}, 16'h0001);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1 chk({15'h0, irq_out}, 16'h0000);
    wait_ev(1'b1, 1, 40 * TP);
    chk(16'(rst_cyc - nmi_cyc), 16'(16 * TP + 1));
    chk(16'(nmi_cnt), 16'h0001);
    rd(ADDR_COUNT, 16'h00FF);
    wr(ADDR_MASK, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk({15'h0, irq_out}, 16'h0000);
    wr(ADDR_STAT, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_CTRL, 16'h0001);
    @(posedge clk_in);
    dbg_halt_in <= 1'b1;
    wr(ADDR_COUNT, 16'h0020);
    repeat (5 * TP) @(posedge clk_in);
    rd(ADDR_COUNT, 16'h0020);
    @(posedge clk_in);
    dbg_halt_in <= 1'b0;
    frz(1'b1);
    wr(ADDR_COUNT, 16'h0003);
    wait_ev(1'b1, 2, 6 * TP);
    chk(16'(nmi_cnt), 16'h0001);
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    @(posedge clk_in);
    sw_rst_in <= 1'b1;
    @(posedge clk_in);
    sw_rst_in <= 1'b0;
    rd(ADDR_CTRL, 16'h0000);
    close_out;
  end
endmodule
